// ---- rtl/nvl_flash_rd.sv ----
// flash read port sequencer: byte fetch with valid_o three cycles after req_i
`timescale 1ns/1ps
module nvl_flash_rd
    import nvl_pkg::*;
(
    input  wire logic        core_clk_i,
    input  wire logic        reset_n_i,
    input  wire logic        req_i,
    input  wire logic [15:0] addr_i,
    input  wire logic [7:0]  fl_rdata_i,
    output logic             fl_rd_o,
    output logic [15:0]      fl_addr_o,
    output logic             valid_o,
    output logic [7:0]       data_o
);
    logic rd_q;

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            fl_rd_o   <= 1'b0;
            fl_addr_o <= 16'h0000;
        end else begin
            fl_rd_o   <= req_i;
            fl_addr_o <= req_i ? addr_i : fl_addr_o;
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rd_q    <= 1'b0;
            valid_o <= 1'b0;
            data_o  <= 8'h00;
        end else begin
            // flash answers one cycle after it takes the request
            rd_q    <= fl_rd_o;
            valid_o <= rd_q;
            data_o  <= rd_q ? fl_rdata_i : data_o;
        end
    end
endmodule

// ---- rtl/nvl_key_cmp.sv ----
// backdoor key comparator: collects eight presented bytes and compares
`timescale 1ns/1ps
module nvl_key_cmp
    import nvl_pkg::*;
(
    input  wire logic        core_clk_i,
    input  wire logic        reset_n_i,
    input  wire logic        clear_i,
    input  wire logic        byte_we_i,
    input  wire logic [7:0]  byte_i,
    input  wire logic [63:0] key_i,
    output logic             full_o,
    output logic             match_o
);
    logic [7:0] presented [8];
    logic [3:0] count;
    logic [7:0] byte_eq;

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            count <= 4'h0;
        end else if (clear_i) begin
            count <= 4'h0;
        end else if (byte_we_i && count != NVL_KEY_BYTES) begin
            count <= count + 4'h1;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (byte_we_i && count != NVL_KEY_BYTES) begin
            presented[count[2:0]] <= byte_i;
        end
    end

    // byte 0 of the key is the lowest flash address
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_cmp
            assign byte_eq[g] = (presented[g] == key_i[8*g +: 8]);
        end
    endgenerate

    assign full_o  = (count == NVL_KEY_BYTES);
    assign match_o = full_o && (&byte_eq);
endmodule

// ---- rtl/nvl_loader.sv ----
// top: reset-time nonvolatile loader and backdoor security gate
`timescale 1ns/1ps
module nvl_loader
    import nvl_pkg::*;
(
    input  wire logic        core_clk_i,
    input  wire logic        reset_n_i,
    input  wire logic        debug_mode_i,
    input  wire logic        exec_secure_i,
    input  wire logic        access_debug_i,
    input  wire logic [7:0]  factory_trim_i,
    input  wire logic        factory_fine_trim_i,
    input  wire logic [63:0] key_store_i,
    input  wire logic [7:0]  fl_rdata_i,
    input  wire logic        mass_erase_done_i,
    input  wire logic [3:0]  reg_addr_i,
    input  wire logic [7:0]  reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic [7:0]       reg_rdata_o,
    output logic             fl_rd_o,
    output logic [15:0]      fl_addr_o,
    output logic             secure_o,
    output logic             load_done_o,
    output logic [7:0]       working_protection_reg_o,
    output logic [7:0]       working_option_reg_o,
    output logic [7:0]       clock_gen_trim_reg_o,
    output logic             fine_trim_o
);
    nvl_state_t  state;
    nvl_state_t  next_state;
    logic        rd_req;
    logic [15:0] rd_addr;
    logic        rd_valid;
    logic [7:0]  rd_data;
    logic        debug_at_reset;
    logic [7:0]  working_protection_reg;
    logic [7:0]  working_option_reg;
    logic [7:0]  clock_gen_trim_reg;
    logic [7:0]  clock_gen_status_reg;
    logic [7:0]  fine_trim_store;
    logic        secure;
    logic        loaded;
    logic        key_ok;
    logic        key_fail;
    logic        reject;
    logic        key_clear;
    logic        key_full;
    logic        key_full_q;
    logic        key_match;
    logic        key_byte_we;
    logic        key_start;
    logic        key_allowed;
    logic        key_enable_bit;
    logic [7:0]  status_byte;

    nvl_flash_rd u_rd (
        .core_clk_i (core_clk_i),
        .reset_n_i  (reset_n_i),
        .req_i      (rd_req),
        .addr_i     (rd_addr),
        .fl_rdata_i (fl_rdata_i),
        .fl_rd_o    (fl_rd_o),
        .fl_addr_o  (fl_addr_o),
        .valid_o    (rd_valid),
        .data_o     (rd_data)
    );

    assign key_enable_bit = working_option_reg[NVL_OPT_KEY_ENABLE_BIT_BIT];
    assign key_allowed = key_enable_bit && exec_secure_i && !access_debug_i;
    assign key_byte_we = reg_wr_i && reg_addr_i == NVL_REG_KEY_DATA && key_allowed;
    assign key_start   = reg_wr_i && reg_addr_i == NVL_REG_KEY_CTRL && reg_wdata_i[NVL_KC_START];
    assign key_clear   = key_start || state != NVL_DONE;

    nvl_key_cmp u_key (
        .core_clk_i (core_clk_i),
        .reset_n_i  (reset_n_i),
        .clear_i    (key_clear),
        .byte_we_i  (key_byte_we),
        .byte_i     (reg_wdata_i),
        .key_i      (key_store_i),
        .full_o     (key_full),
        .match_o    (key_match)
    );

    // load sequence: one flash byte per step, waits for each answer
    always_comb begin
        next_state = state;
        rd_req     = 1'b0;
        rd_addr    = NVL_ADDR_PROT_STORE;
        case (state)
            NVL_IDLE: begin
                rd_req     = 1'b1;
                next_state = NVL_RD_PROT;
            end
            NVL_RD_PROT: begin
                if (rd_valid) begin
                    rd_req     = 1'b1;
                    rd_addr    = NVL_ADDR_OPT_STORE;
                    next_state = NVL_RD_OPT;
                end
            end
            NVL_RD_OPT: begin
                if (rd_valid) begin
                    rd_req     = 1'b1;
                    rd_addr    = NVL_ADDR_FINE_TRIM_STORE;
                    next_state = NVL_RD_FT;
                end
            end
            NVL_RD_FT: begin
                if (rd_valid) begin
                    rd_req     = 1'b1;
                    rd_addr    = NVL_ADDR_CTRIM_STORE;
                    next_state = NVL_RD_CT;
                end
            end
            NVL_RD_CT: begin
                if (rd_valid) begin
                    next_state = NVL_DONE;
                end
            end
            NVL_DONE: begin
                next_state = NVL_DONE;
            end
            default: begin
                next_state = NVL_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state <= NVL_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // debug mode is caught just after reset release, not as a reset value
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            debug_at_reset <= 1'b0;
        end else if (state == NVL_IDLE) begin
            debug_at_reset <= debug_mode_i;
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            working_protection_reg <= NVL_ZERO8;
        end else if (state == NVL_RD_PROT && rd_valid) begin
            working_protection_reg <= rd_data;
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            working_option_reg <= NVL_ZERO8;
        end else if (state == NVL_RD_OPT && rd_valid) begin
            working_option_reg <= rd_data;
        end
    end

    // keep only bit 0 of the fine trim byte
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            fine_trim_store <= NVL_ZERO8;
        end else if (state == NVL_RD_FT && rd_valid) begin
            fine_trim_store <= {7'h00, rd_data[NVL_FINE_TRIM_BIT]};
        end
    end

    // factory trim, or debug default trim in debug mode, loaded at the end of the sequence; software may override
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            clock_gen_trim_reg   <= NVL_DEBUG_TRIM;
            clock_gen_status_reg <= NVL_ZERO8;
        end else if (state == NVL_RD_CT && rd_valid) begin
            if (debug_at_reset) begin
                clock_gen_trim_reg                  <= NVL_DEBUG_TRIM;
                clock_gen_status_reg[NVL_FINE_TRIM_BIT] <= NVL_DEBUG_FINE_TRIM;
            end else begin
                clock_gen_trim_reg                  <= factory_trim_i;
                clock_gen_status_reg[NVL_FINE_TRIM_BIT] <= factory_fine_trim_i;
            end
        end else if (state == NVL_DONE && reg_wr_i && reg_addr_i == NVL_REG_CTRIM) begin
            clock_gen_trim_reg <= reg_wdata_i;
        end else if (state == NVL_DONE && reg_wr_i && reg_addr_i == NVL_REG_CGSTAT) begin
            clock_gen_status_reg[NVL_FINE_TRIM_BIT] <= reg_wdata_i[NVL_FINE_TRIM_BIT];
        end
    end

    // security state: secure until loaded field proves otherwise
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            secure <= 1'b1;
        end else if (state == NVL_RD_OPT && rd_valid) begin
            secure <= (rd_data[1:0] != NVL_SEC_UNSECURED);
        end else if (state == NVL_DONE && key_full && key_match && key_enable_bit) begin
            secure <= 1'b0;
        end else if (state == NVL_DONE && mass_erase_done_i && reg_wr_i && reg_addr_i == NVL_REG_ERASE_CTRL
                     && reg_wdata_i[NVL_EC_BLANK_OK]) begin
            secure <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            loaded <= 1'b0;
        end else if (state == NVL_RD_CT && rd_valid) begin
            loaded <= 1'b1;
        end
    end

    // result flags: a new event wins over the clearing restart
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            key_full_q <= 1'b0;
            key_ok     <= 1'b0;
            key_fail   <= 1'b0;
        end else begin
            // verdict on the rise of full only, so a restart really clears
            key_full_q <= key_full;
            if (state == NVL_DONE && key_full && !key_full_q) begin
                key_ok   <= key_match && key_enable_bit;
                key_fail <= !(key_match && key_enable_bit);
            end else if (key_start) begin
                key_ok   <= 1'b0;
                key_fail <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            reject <= 1'b0;
        end else if (reg_wr_i && reg_addr_i == NVL_REG_KEY_DATA && !key_allowed) begin
            reject <= 1'b1;
        end else if (key_start) begin
            reject <= 1'b0;
        end
    end

    always_comb begin
        status_byte                  = NVL_ZERO8;
        status_byte[NVL_ST_SECURE]   = secure;
        status_byte[NVL_ST_LOADED]   = loaded;
        status_byte[NVL_ST_KEY_OK]   = key_ok;
        status_byte[NVL_ST_KEY_FAIL] = key_fail;
        status_byte[NVL_ST_REJECT]   = reject;
    end

    // read data valid the cycle after the strobe only
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            reg_rdata_o <= NVL_ZERO8;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                NVL_REG_STATUS: reg_rdata_o <= status_byte;
                NVL_REG_WPROT:  reg_rdata_o <= working_protection_reg;
                NVL_REG_WOPT:   reg_rdata_o <= working_option_reg;
                NVL_REG_CTRIM:  reg_rdata_o <= clock_gen_trim_reg;
                NVL_REG_CGSTAT: reg_rdata_o <= clock_gen_status_reg;
                default:        reg_rdata_o <= NVL_ZERO8;
            endcase
        end else begin
            reg_rdata_o <= NVL_ZERO8;
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            secure_o                 <= 1'b1;
            load_done_o              <= 1'b0;
            working_protection_reg_o <= NVL_ZERO8;
            working_option_reg_o     <= NVL_ZERO8;
            clock_gen_trim_reg_o     <= NVL_DEBUG_TRIM;
            fine_trim_o              <= 1'b0;
        end else begin
            secure_o                 <= secure;
            load_done_o              <= loaded;
            working_protection_reg_o <= working_protection_reg;
            working_option_reg_o     <= working_option_reg;
            clock_gen_trim_reg_o     <= clock_gen_trim_reg;
            fine_trim_o              <= clock_gen_status_reg[NVL_FINE_TRIM_BIT] | fine_trim_store[7];
        end
    end
endmodule

// ---- rtl/nvl_pkg.sv ----
// package: nonvolatile loader constants, offsets and field layouts
package nvl_pkg;
    // flash-side addresses of the nonvolatile bytes
    localparam logic [15:0] NVL_ADDR_FINE_TRIM_STORE  = 16'hffae;
    localparam logic [15:0] NVL_ADDR_CTRIM_STORE  = 16'hffaf;
    localparam logic [15:0] NVL_ADDR_KEY_BASE     = 16'hffb0;
    localparam logic [15:0] NVL_ADDR_PROT_STORE   = 16'hffbd;
    localparam logic [15:0] NVL_ADDR_OPT_STORE    = 16'hffbf;
    localparam logic [3:0]  NVL_KEY_BYTES         = 4'h8;
    // register port offsets
    localparam logic [3:0]  NVL_REG_STATUS        = 4'h0;
    localparam logic [3:0]  NVL_REG_WPROT         = 4'h1;
    localparam logic [3:0]  NVL_REG_WOPT          = 4'h2;
    localparam logic [3:0]  NVL_REG_CTRIM         = 4'h3;
    localparam logic [3:0]  NVL_REG_CGSTAT        = 4'h4;
    localparam logic [3:0]  NVL_REG_KEY_DATA      = 4'h5;
    localparam logic [3:0]  NVL_REG_KEY_CTRL      = 4'h6;
    localparam logic [3:0]  NVL_REG_ERASE_CTRL    = 4'h7;
    // option byte fields
    localparam int          NVL_OPT_KEY_ENABLE_BIT_BIT     = 7;
    localparam logic [1:0]  NVL_SEC_UNSECURED     = 2'h2;
    // status bits
    localparam int          NVL_ST_SECURE         = 0;
    localparam int          NVL_ST_LOADED         = 1;
    localparam int          NVL_ST_KEY_OK         = 2;
    localparam int          NVL_ST_KEY_FAIL       = 3;
    localparam int          NVL_ST_REJECT         = 4;
    // control bits
    localparam int          NVL_KC_START          = 0;
    localparam int          NVL_EC_BLANK_OK       = 0;
    // trim values
    localparam logic [7:0]  NVL_DEBUG_TRIM        = 8'h80;
    localparam logic        NVL_DEBUG_FINE_TRIM       = 1'h0;
    localparam int          NVL_FINE_TRIM_BIT         = 0;
    localparam logic [7:0]  NVL_ZERO8             = 8'h00;
    typedef enum logic [2:0] {NVL_IDLE, NVL_RD_PROT, NVL_RD_OPT, NVL_RD_FT, NVL_RD_CT, NVL_DONE} nvl_state_t;
endpackage

// ---- verification/nvl_flash_model.sv ----
// flash array model: serves the nonvolatile configuration bytes
`timescale 1ns/1ps
module nvl_flash_model
    import nvl_pkg::*;
(
    input  wire logic        core_clk_i,
    input  wire logic        fl_rd_i,
    input  wire logic [15:0] fl_addr_i,
    input  wire logic [7:0]  prot_i,
    input  wire logic [7:0]  opt_i,
    input  wire logic        fine_trim_i,
    input  wire logic [7:0]  ctrim_i,
    output logic      [7:0]  fl_rdata_o
);
    initial fl_rdata_o = 8'h5a;
    // data holds one cycle, then toggles so stale bytes never look valid
    always @(posedge core_clk_i) begin
        if (fl_rd_i) begin
            case (fl_addr_i)
                NVL_ADDR_FINE_TRIM_STORE: fl_rdata_o <= {7'h00, fine_trim_i};
                NVL_ADDR_CTRIM_STORE: fl_rdata_o <= ctrim_i;
                NVL_ADDR_PROT_STORE:  fl_rdata_o <= prot_i;
                NVL_ADDR_OPT_STORE:   fl_rdata_o <= opt_i & 8'he3;
                default:              fl_rdata_o <= 8'hff;
            endcase
        end else begin
            fl_rdata_o <= ~fl_rdata_o;
        end
    end
endmodule

// ---- verification/nvl_loader_bench.sv ----
// self-checking bench for the nonvolatile loader and key gate
`timescale 1ns/1ps
module nvl_loader_bench
    import nvl_pkg::*;
();
    logic        core_clk;
    logic        reset_n;
    logic        debug_mode;
    logic        exec_secure;
    logic        access_debug;
    logic [7:0]  factory_trim;
    logic        factory_fine_trim;
    logic [63:0] key_store;
    logic        mass_erase_done;
    logic [3:0]  reg_addr;
    logic [7:0]  reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_rdata;
    logic        fl_rd;
    logic [15:0] fl_addr;
    logic [7:0]  fl_rdata;
    logic        secure;
    logic        load_done;
    logic [7:0]  wprot;
    logic [7:0]  wopt;
    logic [7:0]  trim;
    logic        fine_trim;
    logic [7:0]  prot_b;
    logic [7:0]  opt_b;
    logic        fine_trim_b;
    logic [7:0]  ctrim_b;
    logic [7:0]  rdv;
    int          fails;
    int          comparisons;

    nvl_loader u_dut (.core_clk_i(core_clk), .reset_n_i(reset_n), .debug_mode_i(debug_mode),
        .exec_secure_i(exec_secure), .access_debug_i(access_debug), .factory_trim_i(factory_trim),
        .factory_fine_trim_i(factory_fine_trim), .key_store_i(key_store), .fl_rdata_i(fl_rdata),
        .mass_erase_done_i(mass_erase_done), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
        .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .fl_rd_o(fl_rd), .fl_addr_o(fl_addr),
        .secure_o(secure), .load_done_o(load_done), .working_protection_reg_o(wprot),
        .working_option_reg_o(wopt), .clock_gen_trim_reg_o(trim), .fine_trim_o(fine_trim));
    nvl_flash_model u_flash (.core_clk_i(core_clk), .fl_rd_i(fl_rd), .fl_addr_i(fl_addr), .prot_i(prot_b),
        .opt_i(opt_b), .fine_trim_i(fine_trim_b), .ctrim_i(ctrim_b), .fl_rdata_o(fl_rdata));

    always #2 core_clk = ~core_clk;

    function automatic logic exp_secure(input logic [7:0] opt);
        return opt[1:0] != NVL_SEC_UNSECURED;
    endfunction

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    // reset, wait for the load, then compare every loaded output
    task automatic load_round(input logic dbg);
        @(posedge core_clk);
        reset_n <= 1'b0;
        debug_mode <= dbg;
        repeat (8) @(posedge core_clk);
        reset_n <= 1'b1;
        for (int i = 0; i < 60 && load_done !== 1'b1; i++) @(posedge core_clk);
        @(posedge core_clk);
        check(load_done, 1'b1);
        check(wprot, prot_b);
        check(wopt, opt_b & 8'he3);
        check(trim, dbg ? NVL_DEBUG_TRIM : factory_trim);
        check(fine_trim, dbg ? NVL_DEBUG_FINE_TRIM : factory_fine_trim);
        check(secure, exp_secure(opt_b));
        rd(NVL_REG_STATUS, rdv);
        check(rdv[1:0], {1'b1, exp_secure(opt_b)});
        rd(NVL_REG_WOPT, rdv);
        check(rdv, opt_b & 8'he3);
    endtask

    // restart, present eight bytes low first, poll for a verdict
    task automatic key_try(input logic [63:0] k, input logic src, input logic dbg, input logic [2:0] exp);
        exec_secure <= src;
        access_debug <= dbg;
        wr(NVL_REG_KEY_CTRL, 8'h01);
        for (int b = 0; b < 8; b++) wr(NVL_REG_KEY_DATA, k[b*8 +: 8]);
        rdv = 8'h00;
        for (int i = 0; i < 20 && rdv[4:2] == 3'b000; i++) rd(NVL_REG_STATUS, rdv);
        check(rdv[4:2], exp);
        repeat (2) @(posedge core_clk);
    endtask

    initial begin
        core_clk = 1'b0;
        reset_n = 1'b0;
        {debug_mode, exec_secure, access_debug, factory_fine_trim, mass_erase_done, reg_wr, reg_rd} = 7'h00;
        {factory_trim, reg_wdata, prot_b, opt_b, ctrim_b, rdv} = 48'h0;
        reg_addr = 4'h0;
        fine_trim_b = 1'b0;
        key_store = 64'h0;
        fails = 0;
        comparisons = 0;
        void'($urandom(32'h36d1));
        // every security code, both trim sources
        for (int n = 0; n < 12; n++) begin
            prot_b <= $urandom;
            opt_b <= {$urandom} & 8'hfc | n[1:0];
            fine_trim_b <= $urandom;
            ctrim_b <= $urandom;
            factory_trim <= $urandom;
            factory_fine_trim <= $urandom;
            load_round(n < 4 ? n[0] : $urandom);
        end
        // software override of the trim
        rdv = $urandom;
        wr(NVL_REG_CTRIM, rdv);
        wr(NVL_REG_CGSTAT, 8'h01);
        repeat (2) @(posedge core_clk);
        check(trim, rdv);
        check(fine_trim, 1'b1);
        rd(NVL_REG_CGSTAT, rdv);
        check(rdv, 8'h01);
        // read-only copies ignore writes, unmapped reads give zero
        wr(NVL_REG_WPROT, ~prot_b);
        repeat (2) @(posedge core_clk);
        check(wprot, prot_b);
        for (int a = 8; a < 16; a++) begin
            rd(a[3:0], rdv);
            check(rdv, 8'h00);
        end
        // key enabled, secured
        key_store <= {$urandom, $urandom};
        opt_b <= 8'h80;
        load_round(1'b0);
        key_try(key_store, 1'b0, 1'b0, 3'b100);
        check(secure, 1'b1);
        key_try(key_store, 1'b1, 1'b1, 3'b100);
        check(secure, 1'b1);
        key_try(key_store ^ 64'h0100_0000_0000_0000, 1'b1, 1'b0, 3'b010);
        check(secure, 1'b1);
        key_try(key_store, 1'b1, 1'b0, 3'b001);
        check(secure, 1'b0);
        // key disabled: only erase with blank check lifts security
        opt_b <= 8'h01;
        load_round(1'b1);
        key_try(key_store, 1'b1, 1'b0, 3'b100);
        check(secure, 1'b1);
        wr(NVL_REG_ERASE_CTRL, 8'h01);
        repeat (3) @(posedge core_clk);
        check(secure, 1'b1);
        mass_erase_done <= 1'b1;
        wr(NVL_REG_ERASE_CTRL, 8'h01);
        repeat (3) @(posedge core_clk);
        check(secure, 1'b0);
        mass_erase_done <= 1'b0;
        stop_test();
    end

    // whole run is well under a thousand cycles
    initial begin
        #(4 * 30000);
        fails++;
        stop_test();
    end
endmodule

// ---- verification/nvl_loader_checker.sv ----
// checker: port-level properties of the nonvolatile loader
`timescale 1ns/1ps
module nvl_loader_checker
    import nvl_pkg::*;
(
    input  wire logic        core_clk_i,
    input  wire logic        reset_n_i,
    input  wire logic        debug_mode_i,
    input  wire logic        exec_secure_i,
    input  wire logic        access_debug_i,
    input  wire logic [7:0]  factory_trim_i,
    input  wire logic        factory_fine_trim_i,
    input  wire logic [7:0]  fl_rdata_i,
    input  wire logic        mass_erase_done_i,
    input  wire logic [3:0]  reg_addr_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    input  wire logic [7:0]  reg_rdata_o,
    input  wire logic        fl_rd_o,
    input  wire logic [15:0] fl_addr_o,
    input  wire logic        secure_o,
    input  wire logic        load_done_o,
    input  wire logic [7:0]  working_protection_reg_o,
    input  wire logic [7:0]  working_option_reg_o,
    input  wire logic [7:0]  clock_gen_trim_reg_o,
    input  wire logic        fine_trim_o
);
    logic        rel_q;
    logic        dbg_cap;
    logic        rd_q;
    logic [15:0] addr_q;
    logic [7:0]  cap_prot;
    logic [7:0]  cap_opt;
    logic        erase_seen;
    logic        good_key;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);

    // debug level only matters in the first cycle after release
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rel_q   <= 1'b0;
            dbg_cap <= 1'b0;
        end else begin
            rel_q <= 1'b1;
            if (!rel_q) begin
                dbg_cap <= debug_mode_i;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rd_q     <= 1'b0;
            addr_q   <= 16'h0000;
            cap_prot <= 8'h00;
            cap_opt  <= 8'h00;
        end else begin
            rd_q   <= fl_rd_o;
            addr_q <= fl_addr_o;
            if (rd_q && addr_q == NVL_ADDR_PROT_STORE) begin
                cap_prot <= fl_rdata_i;
            end
            if (rd_q && addr_q == NVL_ADDR_OPT_STORE) begin
                cap_opt <= fl_rdata_i;
            end
        end
    end

    // only these two events may legally lift security
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            erase_seen <= 1'b0;
            good_key   <= 1'b0;
        end else begin
            if (reg_wr_i && reg_addr_i == NVL_REG_ERASE_CTRL && mass_erase_done_i) begin
                erase_seen <= 1'b1;
            end
            if (reg_wr_i && reg_addr_i == NVL_REG_KEY_DATA && exec_secure_i && !access_debug_i
                && working_option_reg_o[NVL_OPT_KEY_ENABLE_BIT_BIT]) begin
                good_key <= 1'b1;
            end
        end
    end

    property p_prot_copy;
        $rose(load_done_o) |-> working_protection_reg_o == cap_prot;
    endproperty
    a_prot_copy: assert property (p_prot_copy) else $error("protection byte not copied");
    property p_opt_copy;
        $rose(load_done_o) |-> working_option_reg_o == cap_opt;
    endproperty
    a_opt_copy: assert property (p_opt_copy) else $error("option byte not copied");
    property p_factory_trim;
        $rose(load_done_o) && !dbg_cap |-> clock_gen_trim_reg_o == factory_trim_i && fine_trim_o == factory_fine_trim_i;
    endproperty
    a_factory_trim: assert property (p_factory_trim) else $error("factory trim not loaded");
    property p_debug_trim;
        $rose(load_done_o) && dbg_cap |-> clock_gen_trim_reg_o == NVL_DEBUG_TRIM && fine_trim_o == NVL_DEBUG_FINE_TRIM;
    endproperty
    a_debug_trim: assert property (p_debug_trim) else $error("debug default trim not loaded");
    property p_secure_load;
        $rose(load_done_o) |-> secure_o == (working_option_reg_o[1:0] != NVL_SEC_UNSECURED);
    endproperty
    a_secure_load: assert property (p_secure_load) else $error("secure state wrong after load");
    property p_key_enable_bit_gate;
        $fell(secure_o) && $past(load_done_o) |-> working_option_reg_o[NVL_OPT_KEY_ENABLE_BIT_BIT] || erase_seen;
    endproperty
    a_key_enable_bit_gate: assert property (p_key_enable_bit_gate) else $error("security lifted with key disabled");
    property p_key_source;
        $fell(secure_o) && $past(load_done_o) |-> good_key || erase_seen;
    endproperty
    a_key_source: assert property (p_key_source) else $error("security lifted from bad source");
    property p_rdata_idle;
        !$past(reg_rd_i) |-> reg_rdata_o == NVL_ZERO8;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
    property p_status_loaded;
        $past(reg_rd_i) && $past(reg_addr_i) == NVL_REG_STATUS |-> reg_rdata_o[NVL_ST_LOADED] == load_done_o;
    endproperty
    a_status_loaded: assert property (p_status_loaded) else $error("status loaded bit wrong");
    property p_one_read;
        fl_rd_o |=> !fl_rd_o;
    endproperty
    a_one_read: assert property (p_one_read) else $error("flash read not a single pulse");
endmodule

bind nvl_loader nvl_loader_checker u_chk (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
    .debug_mode_i(debug_mode_i), .exec_secure_i(exec_secure_i), .access_debug_i(access_debug_i),
    .factory_trim_i(factory_trim_i), .factory_fine_trim_i(factory_fine_trim_i), .fl_rdata_i(fl_rdata_i),
    .mass_erase_done_i(mass_erase_done_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .fl_rd_o(fl_rd_o), .fl_addr_o(fl_addr_o),
    .secure_o(secure_o), .load_done_o(load_done_o), .working_protection_reg_o(working_protection_reg_o),
    .working_option_reg_o(working_option_reg_o), .clock_gen_trim_reg_o(clock_gen_trim_reg_o),
    .fine_trim_o(fine_trim_o));
